// ===== tlip_arbiter.sv
// tlip_arbiter: picks one request by level, then by fixed poll order.
// assumes requests already gated by enables; purely combinational.
`default_nettype none
module tlip_arbiter
  import tlip_pkg::*;
(
  input  wire logic [10:0] req_in,      // gated requests, poll order
  input  wire logic [10:0] prio_hi_in,  // one means high level
  input  wire logic        allow_hi_in, // high level may enter
  input  wire logic        allow_lo_in, // low level may enter
  output var tlip_pick_t   pick_out     // chosen source
);
  function automatic logic [3:0] first_set(input logic [10:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [10:0] hi_req;
  logic [10:0] lo_req;

  always_comb begin
    hi_req = req_in & prio_hi_in & {11{allow_hi_in}};
    lo_req = req_in & ~prio_hi_in & {11{allow_lo_in}};
    pick_out.valid = |hi_req || |lo_req;
    pick_out.high  = |hi_req;
    pick_out.idx   = |hi_req ? first_set(hi_req) : first_set(lo_req);
  end
endmodule
`default_nettype wire

// ===== tlip_core_model.sv
// tlip_core_model: core fetch, stack and return logic facing the block.
// assumes one clock; bench asks for returns through ret_req_in.
`default_nettype none
module tlip_core_model (
  input  wire logic        clk_in,       // core clock
  input  wire logic        rst_b_in,     // async reset, active low
  input  wire logic        push_in,      // stack push pulse
  input  wire logic [15:0] push_data_in, // value pushed
  input  wire logic        load_in,      // pc load pulse
  input  wire logic [15:0] vector_in,    // vector to load
  input  wire logic        ret_req_in,   // bench asks a return
  output logic             boundary_out, // may accept now
  output logic      [15:0] pc_out,       // program counter
  output logic             reti_out,     // return pulse
  output logic             push_bad_out  // sticky: wrong value pushed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pc_prev;

  // boundary stalls at random so entry waits on the core
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boundary_out <= 1'b0;
      pc_out       <= 16'h1000;
      pc_prev      <= 16'h1000;
      reti_out     <= 1'b0;
      push_bad_out <= 1'b0;
    end else begin
      boundary_out <= ($urandom % 4) != 0;
      pc_prev      <= pc_out;
      pc_out       <= load_in ? vector_in : pc_out + 16'h0001;
      reti_out     <= ret_req_in;
      if (push_in && push_data_in !== pc_prev) begin
        push_bad_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tlip_pkg.sv
// tlip_pkg: constants and types of the two-level interrupt priority block.
// assumes one core clock domain; register indices are byte address / 4.
`default_nettype none
package tlip_pkg;
  localparam int unsigned TLIP_NSRC = 11;
  localparam int unsigned TLIP_IDXW = 4;

  // poll order, position 0 is polled first
  localparam logic [3:0] TLIP_SRC_PSM  = 4'h0;
  localparam logic [3:0] TLIP_SRC_WDT  = 4'h1;
  localparam logic [3:0] TLIP_SRC_EXT0 = 4'h2;
  localparam logic [3:0] TLIP_SRC_ADC  = 4'h3;
  localparam logic [3:0] TLIP_SRC_T0   = 4'h4;
  localparam logic [3:0] TLIP_SRC_EXT1 = 4'h5;
  localparam logic [3:0] TLIP_SRC_T1   = 4'h6;
  localparam logic [3:0] TLIP_SRC_SER  = 4'h7;
  localparam logic [3:0] TLIP_SRC_UART = 4'h8;
  localparam logic [3:0] TLIP_SRC_T2   = 4'h9;
  localparam logic [3:0] TLIP_SRC_ITV  = 4'hA;

  // vector per poll position, position 10 first
  localparam logic [10:0][15:0] TLIP_VEC = {
    16'h0053, 16'h002B, 16'h0023, 16'h003B, 16'h001B, 16'h0013,
    16'h000B, 16'h0033, 16'h0003, 16'h005B, 16'h0043};

  // register indices; byte address is index * 4
  localparam logic [7:0] TLIP_IDX_IE     = 8'hA8;
  localparam logic [7:0] TLIP_IDX_ENPRI  = 8'hA9;
  localparam logic [7:0] TLIP_IDX_IPA    = 8'hB8;
  localparam logic [7:0] TLIP_IDX_WDCFG  = 8'hC0;
  localparam logic [7:0] TLIP_IDX_STATUS = 8'hC1;
  localparam logic [7:0] TLIP_IDX_MASK   = 8'hC2;
  localparam logic [7:0] TLIP_IDX_STATE  = 8'hC3;

  localparam logic [7:0] TLIP_RST_IE     = 8'h00;
  localparam logic [7:0] TLIP_RST_ENPRI  = 8'hA0;
  localparam logic [7:0] TLIP_RST_IPA    = 8'h00;
  localparam logic [7:0] TLIP_RST_WDCFG  = 8'h00;
  localparam logic [2:0] TLIP_RST_STATUS = 3'h0;
  localparam logic [2:0] TLIP_RST_MASK   = 3'h0;

  // field positions
  localparam int unsigned TLIP_IE_GLOBAL   = 7;
  localparam int unsigned TLIP_WD_MODE     = 7;
  localparam int unsigned TLIP_B_ITV_PRIO  = 6;
  localparam int unsigned TLIP_B_PSM_PRIO  = 5;
  localparam int unsigned TLIP_B_SER_PRIO  = 4;
  localparam int unsigned TLIP_B_ITV_EN    = 2;
  localparam int unsigned TLIP_B_PSM_EN    = 1;
  localparam int unsigned TLIP_B_SER_EN    = 0;
  localparam int unsigned TLIP_ST_ACCEPT   = 0;
  localparam int unsigned TLIP_ST_RETURN   = 1;
  localparam int unsigned TLIP_ST_WDT      = 2;

  typedef enum logic [1:0] {
    TLIP_IDLE = 2'b00,
    TLIP_PUSH = 2'b01,
    TLIP_LOAD = 2'b10
  } tlip_state_t;

  typedef struct packed {
    logic supply_monitor_irq;
    logic ext0_irq_flag;
    logic adc_ready_flags;
    logic timer0_overflow;
    logic ext1_irq_flag;
    logic timer1_overflow;
    logic two_wire_irq_flag;
    logic four_wire_irq_flag;
    logic uart_rx_flag;
    logic uart_tx_flag;
    logic timer2_overflow;
    logic timer2_external_flag;
    logic interval_counter_irq;
  } tlip_flags_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  idx;
    logic        high;
  } tlip_pick_t;
endpackage
`default_nettype wire

// ===== tlip_top.sv
// tlip_top: two-level interrupt priority and vectoring for an 8051-class core.
// assumes flags and core strobes come from logic on clk_in; Avalon-MM slave.
//
// Our own choice: the Avalon-MM slave port.
`default_nettype none
module tlip_top
  import tlip_pkg::*;
#(
  parameter int unsigned WD_TMO_W = 4
) (
  input  wire logic        clk_in,                // core clock
  input  wire logic        rst_b_in,              // async reset, active low
  input  wire logic [9:0]  avs_address_in,        // byte address
  input  wire logic        avs_read_in,           // read request
  input  wire logic        avs_write_in,          // write request
  input  wire logic [3:0]  avs_byteenable_in,     // lane enables
  input  wire logic [31:0] avs_writedata_in,      // write data
  output logic      [31:0] avs_readdata_out,      // read data
  output logic             avs_waitrequest_out,   // stall
  input  wire tlip_flags_t flags_in,              // peripheral flags
  input  wire logic        watchdog_irq_in,       // watchdog timeout pulse
  input  wire logic        core_boundary_in,      // core may take interrupt
  input  wire logic [15:0] core_pc_in,            // current program counter
  input  wire logic        core_reti_in,          // interrupt return pulse
  output logic             irq_pending_out,       // request waiting
  output logic             stack_push_out,        // push pulse
  output logic      [15:0] stack_data_out,        // value to push
  output logic             pc_load_out,           // load pulse
  output logic      [15:0] pc_vector_out,         // vector to load
  output logic      [10:0] src_ack_out,           // accepted source, poll order
  output logic             irq_out                // unmasked status set
);
  generate
    if (WD_TMO_W < 1 || WD_TMO_W > 7) begin : g_chk
      $error("WD_TMO_W must be 1..7");
    end
  endgenerate

  logic [7:0]  irq_enable_a;           // primary enable, global in bit 7
  logic [7:0]  irq_priority_a;
  logic [7:0]  irq_enable_priority_b;
  logic [7:0]  wd_cfg;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic        wdt_pend;
  logic        active_hi;
  logic        active_lo;
  tlip_state_t state;
  logic [3:0]  taken_idx;
  logic        taken_high;

  logic        global_irq_enable;
  logic        watchdog_irq_mode;
  logic [10:0] raw_req;
  logic [10:0] en_vec;
  logic [10:0] prio_vec;
  logic [10:0] gated_req;
  tlip_pick_t  pick;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        accept;
  logic        do_ret;
  logic [2:0]  st_set;

  assign global_irq_enable = irq_enable_a[TLIP_IE_GLOBAL];
  assign watchdog_irq_mode = wd_cfg[TLIP_WD_MODE];
  assign idx    = avs_address_in[9:2];
  assign wbyte  = avs_writedata_in[7:0];
  assign bus_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign bus_rd = avs_read_in && avs_waitrequest_out;

  // -------- requests, enables, levels
  always_comb begin
    raw_req = {flags_in.interval_counter_irq,
               flags_in.timer2_overflow | flags_in.timer2_external_flag,
               flags_in.uart_rx_flag | flags_in.uart_tx_flag,
               flags_in.two_wire_irq_flag | flags_in.four_wire_irq_flag,
               flags_in.timer1_overflow,
               flags_in.ext1_irq_flag,
               flags_in.timer0_overflow,
               flags_in.adc_ready_flags,
               flags_in.ext0_irq_flag,
               wdt_pend,
               flags_in.supply_monitor_irq};
    en_vec  = {irq_enable_priority_b[TLIP_B_ITV_EN],
               irq_enable_a[5], irq_enable_a[4],
               irq_enable_priority_b[TLIP_B_SER_EN],
               irq_enable_a[3], irq_enable_a[2], irq_enable_a[1],
               irq_enable_a[6], irq_enable_a[0], 1'b0,
               irq_enable_priority_b[TLIP_B_PSM_EN]};
    en_vec  = en_vec & {11{global_irq_enable}};
    en_vec[TLIP_SRC_WDT] = 1'b1;
    prio_vec = {irq_enable_priority_b[TLIP_B_ITV_PRIO],
                irq_priority_a[5], irq_priority_a[4],
                irq_enable_priority_b[TLIP_B_SER_PRIO],
                irq_priority_a[3], irq_priority_a[2], irq_priority_a[1],
                irq_priority_a[6], irq_priority_a[0], 1'b1,
                irq_enable_priority_b[TLIP_B_PSM_PRIO]};
    gated_req = raw_req & en_vec;
  end

  tlip_arbiter u_arb (
    .req_in      (gated_req),
    .prio_hi_in  (prio_vec),
    .allow_hi_in (!active_hi),
    .allow_lo_in (!active_hi && !active_lo),
    .pick_out    (pick)
  );

  assign accept = (state == TLIP_IDLE) && pick.valid && core_boundary_in;
  assign do_ret = core_reti_in && (active_hi || active_lo);

  // -------- register writes; reserved secondary bit 3 is software's duty
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_enable_a          <= TLIP_RST_IE;
      irq_priority_a        <= TLIP_RST_IPA;
      irq_enable_priority_b <= TLIP_RST_ENPRI;
      wd_cfg                <= TLIP_RST_WDCFG;
      mask                  <= TLIP_RST_MASK;
    end else if (bus_wr) begin
      unique case (idx)
        TLIP_IDX_IE:    irq_enable_a <= wbyte;
        TLIP_IDX_IPA:   irq_priority_a <= {1'b0, wbyte[6:0]};
        TLIP_IDX_ENPRI: irq_enable_priority_b <= wbyte;
        TLIP_IDX_WDCFG: wd_cfg <= wbyte;
        TLIP_IDX_MASK:  mask <= wbyte[2:0];
        default: ;
      endcase
    end
  end

  // -------- bus answer: one stall cycle, then done
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
      if (bus_rd) begin
        unique case (idx)
          TLIP_IDX_IE:     avs_readdata_out <= {24'h00_0000, irq_enable_a};
          TLIP_IDX_IPA:    avs_readdata_out <= {24'h00_0000, irq_priority_a};
          TLIP_IDX_ENPRI:  avs_readdata_out <= {24'h00_0000, irq_enable_priority_b};
          TLIP_IDX_WDCFG:  avs_readdata_out <= {24'h00_0000, wd_cfg};
          TLIP_IDX_STATUS: avs_readdata_out <= {29'h0000_0000, status};
          TLIP_IDX_MASK:   avs_readdata_out <= {29'h0000_0000, mask};
          TLIP_IDX_STATE:  avs_readdata_out <= {27'h000_0000, state,
                                                active_hi, active_lo, wdt_pend};
          default:         avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // -------- watchdog pending latch, only with nonzero timeout
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdt_pend <= 1'b0;
    end else if (watchdog_irq_in && watchdog_irq_mode && |wd_cfg[WD_TMO_W-1:0]) begin
      wdt_pend <= 1'b1;
    end else if (state == TLIP_PUSH && taken_idx == TLIP_SRC_WDT) begin
      wdt_pend <= 1'b0;
    end
  end

  // -------- entry sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state          <= TLIP_IDLE;
      taken_idx      <= 4'h0;
      taken_high     <= 1'b0;
      stack_push_out <= 1'b0;
      stack_data_out <= 16'h0000;
      pc_load_out    <= 1'b0;
      pc_vector_out  <= 16'h0000;
      src_ack_out    <= 11'h000;
    end else begin
      stack_push_out <= 1'b0;
      pc_load_out    <= 1'b0;
      src_ack_out    <= 11'h000;
      unique case (state)
        TLIP_IDLE: begin
          if (accept) begin
            state          <= TLIP_PUSH;
            taken_idx      <= pick.idx;
            taken_high     <= pick.high;
            stack_push_out <= 1'b1;
            stack_data_out <= core_pc_in;
          end
        end
        TLIP_PUSH: begin
          state         <= TLIP_LOAD;
          pc_load_out   <= 1'b1;
          pc_vector_out <= TLIP_VEC[taken_idx];
          src_ack_out   <= 11'(1) << taken_idx;
        end
        TLIP_LOAD: state <= TLIP_IDLE;
      endcase
    end
  end

  // -------- in-service levels
  // a return in the push cycle is dropped: no routine can end before it starts
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_hi <= 1'b0;
      active_lo <= 1'b0;
    end else if (state == TLIP_PUSH) begin
      if (taken_high) begin
        active_hi <= 1'b1;
      end else begin
        active_lo <= 1'b1;
      end
    end else if (do_ret) begin
      if (active_hi) begin
        active_hi <= 1'b0;
      end else begin
        active_lo <= 1'b0;
      end
    end
  end

  // -------- sticky events, write one to clear, set wins
  always_comb begin
    st_set = 3'h0;
    st_set[TLIP_ST_ACCEPT] = accept;
    st_set[TLIP_ST_RETURN] = do_ret && (state != TLIP_PUSH);
    st_set[TLIP_ST_WDT]    = watchdog_irq_in && watchdog_irq_mode
                             && |wd_cfg[WD_TMO_W-1:0];
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status <= TLIP_RST_STATUS;
    end else if (bus_wr && idx == TLIP_IDX_STATUS) begin
      status <= (status & ~wbyte[2:0]) | st_set;
    end else begin
      status <= status | st_set;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out         <= 1'b0;
      irq_pending_out <= 1'b0;
    end else begin
      irq_out         <= |(status & mask);
      irq_pending_out <= pick.valid && (state == TLIP_IDLE);
    end
  end

  // -------- checks
  function automatic logic src_enabled(input logic [3:0] s, input logic [7:0] a,
                                       input logic [7:0] b);
    logic [10:0] e;
    e = {b[2], a[5], a[4], b[0], a[3], a[2], a[1], a[6], a[0], 1'b1, b[1]};
    return e[s];
  endfunction

  sequence s_load;
    pc_load_out && !stack_push_out;
  endsequence
  sequence s_back;
    !pc_load_out && state == TLIP_IDLE;
  endsequence

  property p_entry;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(stack_push_out) |-> ##1 s_load ##1 s_back;
  endproperty
  a_entry: assert property (p_entry) else $error("push not followed by load");

  property p_vector;
    @(posedge clk_in) disable iff (!rst_b_in)
      pc_load_out |-> pc_vector_out == TLIP_VEC[taken_idx]
                      && src_ack_out == (11'(1) << taken_idx);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_wdt_vec;
    @(posedge clk_in) disable iff (!rst_b_in)
      pc_load_out && taken_idx == TLIP_SRC_WDT |-> pc_vector_out == 16'h005B ##1 active_hi;
  endproperty
  a_wdt_vec: assert property (p_wdt_vec) else $error("watchdog entry wrong");

  property p_wdt_zero;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(wdt_pend) |-> $past(watchdog_irq_mode) && $past(|wd_cfg[WD_TMO_W-1:0]);
  endproperty
  a_wdt_zero: assert property (p_wdt_zero) else $error("watchdog with zero timeout");

  property p_global;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(stack_push_out) && taken_idx != TLIP_SRC_WDT |-> $past(global_irq_enable);
  endproperty
  a_global: assert property (p_global) else $error("entry while globally off");

  property p_same_level;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(stack_push_out) |-> !$past(active_hi) && (!$past(active_lo) || taken_high);
  endproperty
  a_same_level: assert property (p_same_level) else $error("same-level preemption");

  property p_level;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(stack_push_out) |=> (taken_high ? active_hi : active_lo);
  endproperty
  a_level: assert property (p_level) else $error("level not recorded");

  property p_enabled;
    @(posedge clk_in) disable iff (!rst_b_in)
      $rose(stack_push_out) |->
        src_enabled(taken_idx, $past(irq_enable_a), $past(irq_enable_priority_b));
  endproperty
  a_enabled: assert property (p_enabled) else $error("disabled source taken");

  property p_ret;
    @(posedge clk_in) disable iff (!rst_b_in)
      core_reti_in && active_hi && state == TLIP_IDLE |=>
        !active_hi && active_lo == $past(active_lo) && status[TLIP_ST_RETURN];
  endproperty
  a_ret: assert property (p_ret) else $error("return kept level");

  property p_bus;
    @(posedge clk_in) disable iff (!rst_b_in)
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule
`default_nettype wire

// ===== two_level_interrupt_priority_bench.sv
// two_level_interrupt_priority_bench: self-checking bench for tlip_top.
// assumes the core model file and the design package are compiled first.
`default_nettype none
module two_level_interrupt_priority_bench
  import tlip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_o;
  logic [12:0] fl = 13'h0;
  logic        wdt = 1'b0;
  logic        bnd, reti, ret_req = 1'b0, push_bad;
  logic [15:0] pc, sdata, vec;
  logic        pend, push, load, irq;
  logic [10:0] ack;
  int          err_total = 0;
  int          cmp_count = 0;

  always #2 clk_in = ~clk_in;

  tlip_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .flags_in(tlip_flags_t'(fl)), .watchdog_irq_in(wdt), .core_boundary_in(bnd),
    .core_pc_in(pc), .core_reti_in(reti), .irq_pending_out(pend),
    .stack_push_out(push), .stack_data_out(sdata), .pc_load_out(load),
    .pc_vector_out(vec), .src_ack_out(ack), .irq_out(irq));

  tlip_core_model core_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .push_in(push),
    .push_data_in(sdata), .load_in(load), .vector_in(vec), .ret_req_in(ret_req),
    .boundary_out(bnd), .pc_out(pc), .reti_out(reti), .push_bad_out(push_bad));

  function automatic logic [15:0] vec_of(input int s);
    logic [15:0] t [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
      16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
    return t[s];
  endfunction
  // paired sources carry both flags, so one take clears the whole request
  function automatic logic [12:0] flag_of(input int s);
    logic [12:0] t [11] = '{13'h1000, 13'h0000, 13'h0800, 13'h0400, 13'h0200,
      13'h0100, 13'h0080, 13'h0060, 13'h0018, 13'h0006, 13'h0001};
    return t[s];
  endfunction
  // upper byte: bit in primary enable/priority, lower byte: enable in secondary
  function automatic logic [15:0] en_of(input int s);
    logic [15:0] t [11] = '{16'h0002, 16'h0, 16'h0100, 16'h4000, 16'h0200,
      16'h0400, 16'h0800, 16'h0001, 16'h1000, 16'h2000, 16'h0004};
    return t[s];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr  <= {idx, 2'b00};
    wdata <= {24'h0, d};
    be    <= {3'($urandom), 1'b1};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_o !== 1'b0 && n < 100);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) err_total++;
  endtask
  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd8(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic take(input int s);
    int n;
    logic pp;
    n = 0;
    pp = 1'b0;
    do begin
      @(posedge clk_in);
      n++;
      if (push === 1'b1) pp = pend;
    end while (load !== 1'b1 && n < 200);
    chk("pending", pp, 1'b1);
    chk("vector", {16'h0, vec}, {16'h0, vec_of(s)});
    chk("ack", {21'h0, ack}, 32'h1 << s);
    fl <= fl & ~flag_of(s);
  endtask
  task automatic no_take(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clk_in);
      if (load !== 1'b0) k++;
    end
    chk("no entry", k, 0);
  endtask
  task automatic ret();
    @(posedge clk_in);
    ret_req <= 1'b1;
    @(posedge clk_in);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic raise(input logic [12:0] m);
    @(posedge clk_in);
    fl <= fl | m;
  endtask
  task automatic wd_pulse();
    @(posedge clk_in);
    wdt <= 1'b1;
    @(posedge clk_in);
    wdt <= 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    logic [7:0] r;
    int s0;
    void'($urandom(30302));
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // registers after reset, reserved bits, unmapped place
    rd8("sec reset", TLIP_IDX_ENPRI, 8'hA0);
    rd8("ie reset", TLIP_IDX_IE, 8'h00);
    rd8("ip reset", TLIP_IDX_IPA, 8'h00);
    rd8("unmapped", 8'h10, 8'h00);
    wr8(TLIP_IDX_IPA, 8'hFF);
    rd8("ip bit7", TLIP_IDX_IPA, 8'h7F);
    r = 8'($urandom) & 8'hF7;
    wr8(TLIP_IDX_ENPRI, r);
    rd8("sec rw", TLIP_IDX_ENPRI, r);
    $display("test registers done");
    // every source but the watchdog alone, from a random start
    wr8(TLIP_IDX_IPA, 8'h00);
    wr8(TLIP_IDX_ENPRI, 8'h07);
    wr8(TLIP_IDX_IE, 8'hFF);
    s0 = $urandom % 11;
    for (int i = 0; i < 11; i++) begin
      if ((s0 + i) % 11 != 1) begin
        raise(flag_of((s0 + i) % 11));
        take((s0 + i) % 11);
        ret();
      end
    end
    $display("test vectors done");
    // all at once, same level: poll order, no preemption
    raise(13'h1FFF);
    for (int s = 0; s < 11; s++) begin
      if (s != 1) begin
        take(s);
        if (s == 0) no_take(12);
        ret();
      end
    end
    $display("test poll order done");
    // disabled source never enters
    wr8(TLIP_IDX_ENPRI, 8'h06);
    raise(flag_of(7));
    no_take(20);
    wr8(TLIP_IDX_ENPRI, 8'h07);
    take(7);
    ret();
    // two levels
    wr8(TLIP_IDX_IPA, 8'(en_of(9) >> 8));
    raise(flag_of(2) | flag_of(9));
    take(9);
    no_take(12);
    ret();
    take(2);
    raise(flag_of(9));
    take(9);
    ret();
    raise(flag_of(4));
    no_take(12);
    ret();
    take(4);
    ret();
    $display("test levels done");
    // global disable and watchdog
    wr8(TLIP_IDX_IE, 8'h7F);
    raise(flag_of(2));
    no_take(20);
    chk("no pending", pend, 1'b0);
    fl <= 13'h0;
    wr8(TLIP_IDX_WDCFG, 8'h80);
    wd_pulse();
    no_take(20);
    wr8(TLIP_IDX_WDCFG, 8'h83);
    wd_pulse();
    take(1);
    ret();
    wr8(TLIP_IDX_IE, 8'hFF);
    raise(flag_of(4));
    take(4);
    wd_pulse();
    take(1);
    ret();
    ret();
    $display("test watchdog done");
    // status, mask and interrupt line
    wr8(TLIP_IDX_MASK, 8'h00);
    chk("irq masked", irq, 1'b0);
    rd8("status", TLIP_IDX_STATUS, 8'h07);
    wr8(TLIP_IDX_MASK, 8'h04);
    repeat (2) @(posedge clk_in);
    chk("irq set", irq, 1'b1);
    wr8(TLIP_IDX_STATUS, 8'h07);
    rd8("status clr", TLIP_IDX_STATUS, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("irq clr", irq, 1'b0);
    chk("push value", push_bad, 1'b0);
    $display("test interrupt line done");
    final_report();
  end
endmodule
`default_nettype wire
